// *** verilog/hlr_regs.sv ***
// Summary of operation
// R1: Axis limits: signed upper high byte, lower low
// R2: Limit step is full scale over 128
// R3: Axis limits reset to 7Dh upper, 83h lower
// R4: Thermal limits signed bytes, 4.267 C steps
// R5: Thermal limits reset to 67h and 32h
// R6: Status bit 13 flags valid new data
// R7: Bits 12-8 flag fresh A,T,Z,Y,X data
// R8: Bits 6-4 roll count of completed sets
// R9: Bits 1-0 encode system/front-end flag cause
// R10: Axis results read-only at 9h-Bh, reset zero
// R11: Temperature result read-only at Ch, reset zero
// R12: Limit registers at 4h-7h fully read-write
// R13: Alert after one to four consecutive violations
// R14: Latched alert held until status/result read
// R15: Reserved bits zero, read-only writes ignored
`timescale 1ns/100ps
module hlr_regs
(
	input  wire logic                  clock_i,
	input  wire logic                  rst_b_i,
	input  wire hlr_pkg::hlr_host_req_t host_i,
	output logic                       rd_valid_o,
	output logic [15:0]                rd_data_o,
	input  wire hlr_pkg::hlr_conv_t    conv_i,
	input  wire logic                  afe_flag_i,
	input  wire logic                  sys_flag_i,
	input  wire logic                  alert_latch_i,
	input  wire logic [1:0]            limit_persistence_count_i,
	input  wire logic [3:0]            limit_check_en_i,
	output logic [3:0]                 limit_alert_o
);

	hlr_pkg::hlr_state_t s_reg;
	hlr_pkg::hlr_state_t s_next;

	logic [1:0]  lim_idx;
	logic [1:0]  res_idx;
	logic [3:0]  rd_clear;
	logic [3:0]  hit;
	logic [3:0]  over;
	logic [15:0] status_word;

	assign lim_idx = 2'(host_i.addr - hlr_pkg::OFF_X_LIMITS);
	assign res_idx = 2'(host_i.addr - hlr_pkg::OFF_X_VALUE);

	// ----------------------------------------
	// Status word assembly
	// ----------------------------------------
	always_comb
	begin
		status_word = 16'h0000; // R15
		status_word[hlr_pkg::STAT_VALID_BIT] = s_reg.valid; // R6
		status_word[hlr_pkg::STAT_FRESH_MSB:hlr_pkg::STAT_FRESH_LSB] = s_reg.fresh; // R7
		status_word[hlr_pkg::STAT_SET_MSB:hlr_pkg::STAT_SET_LSB] = s_reg.set_cnt; // R8
		status_word[hlr_pkg::STAT_CAUSE_MSB:hlr_pkg::STAT_CAUSE_LSB] = {sys_flag_i, afe_flag_i}; // R9
	end

	// ----------------------------------------
	// Limit comparison
	// ----------------------------------------
	// Upper byte of a result is full scale over 128 per step, same as the limits
	always_comb
	begin
		for (int i = 0; i < 4; i++)
		begin
			over[i] = limit_check_en_i[i] &&
				(($signed(conv_i.data[i][15:8]) >
				  $signed(s_reg.lim[i][hlr_pkg::UPPER_MSB:hlr_pkg::UPPER_LSB])) ||
				 ($signed(conv_i.data[i][15:8]) <
				  $signed(s_reg.lim[i][hlr_pkg::LOWER_MSB:hlr_pkg::LOWER_LSB]))); // R1 R2 R4
			hit[i] = s_reg.persist[i] > {1'b0, limit_persistence_count_i}; // R13
		end
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		s_next = s_reg;
		s_next.rd_valid = 1'b0;
		rd_clear = 4'h0;

		if (host_i.rd)
		begin
			s_next.rd_valid = 1'b1;
			case (host_i.addr)
				hlr_pkg::OFF_X_LIMITS, hlr_pkg::OFF_Y_LIMITS,
				hlr_pkg::OFF_Z_LIMITS, hlr_pkg::OFF_T_LIMITS:
					s_next.rd_data = s_reg.lim[lim_idx];
				hlr_pkg::OFF_CONV_STATE:
				begin
					s_next.rd_data = status_word;
					rd_clear = 4'hf; // R14
				end
				hlr_pkg::OFF_X_VALUE, hlr_pkg::OFF_Y_VALUE,
				hlr_pkg::OFF_Z_VALUE, hlr_pkg::OFF_T_VALUE:
				begin
					s_next.rd_data = s_reg.res[res_idx]; // R10 R11
					rd_clear[res_idx] = 1'b1; // R14
				end
				default:
					s_next.rd_data = 16'h0000;
			endcase
		end

		// Only the limit words take writes; status and results stay put
		if (host_i.wr)
		begin
			case (host_i.addr)
				hlr_pkg::OFF_X_LIMITS, hlr_pkg::OFF_Y_LIMITS,
				hlr_pkg::OFF_Z_LIMITS, hlr_pkg::OFF_T_LIMITS:
					s_next.lim[lim_idx] = host_i.wdata; // R12
				default:
					s_next.lim = s_reg.lim; // R15
			endcase
		end

		// New conversion marks old data stale; a same-cycle update still sets
		if (conv_i.start)
		begin
			s_next.valid = 1'b0;
			s_next.fresh = 5'h00;
		end
		if (conv_i.angle_upd)
			s_next.fresh[4] = 1'b1; // R7

		for (int i = 0; i < 4; i++)
		begin
			if (conv_i.upd[i])
			begin
				s_next.res[i] = conv_i.data[i]; // R10 R11
				s_next.fresh[i] = 1'b1; // R7
				if (!over[i])
					s_next.persist[i] = 3'h0;
				else if (s_reg.persist[i] != hlr_pkg::PERSIST_MAX)
					s_next.persist[i] = s_reg.persist[i] + 3'h1; // R13
			end
			// Set wins over a read clear so no event is lost
			s_next.latch[i] = (s_reg.latch[i] & ~rd_clear[i]) | hit[i]; // R14
			s_next.alert[i] = alert_latch_i ? s_next.latch[i] : hit[i];
		end

		if (conv_i.done)
		begin
			s_next.valid = 1'b1; // R6
			s_next.set_cnt = s_reg.set_cnt + 3'h1; // R8
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
			s_reg <= hlr_pkg::STATE_RESET; // R3 R5 R10 R11
		else
			s_reg <= s_next;
	end

	assign rd_valid_o    = s_reg.rd_valid;
	assign rd_data_o     = s_reg.rd_data;
	assign limit_alert_o = s_reg.alert;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_limit_write_reads_back;
		@(posedge clock_i) disable iff (!rst_b_i)
		host_i.wr && host_i.addr == hlr_pkg::OFF_Y_LIMITS
		|=> s_reg.lim[1] == $past(host_i.wdata);
	endproperty
	a_limit_write_reads_back: assert property (p_limit_write_reads_back) else $error("limit readback wrong"); // R12

	property p_axis_reset;
		@(posedge clock_i)
		!rst_b_i |=> s_reg.lim[0] == 16'h7d83 && s_reg.lim[2] == 16'h7d83;
	endproperty
	a_axis_reset: assert property (p_axis_reset) else $error("axis limit reset wrong"); // R3

	property p_thermal_reset;
		@(posedge clock_i)
		!rst_b_i |=> s_reg.lim[3] == 16'h6732 && s_reg.res[3] == 16'h0000;
	endproperty
	a_thermal_reset: assert property (p_thermal_reset) else $error("thermal reset wrong"); // R5

	property p_done_sets_valid;
		@(posedge clock_i) disable iff (!rst_b_i)
		conv_i.done |=> s_reg.valid;
	endproperty
	a_done_sets_valid: assert property (p_done_sets_valid) else $error("valid not set"); // R6

	property p_start_clears_fresh;
		@(posedge clock_i) disable iff (!rst_b_i)
		conv_i.start && !conv_i.done && conv_i.upd == 4'h0 && !conv_i.angle_upd
		|=> !s_reg.valid && s_reg.fresh == 5'h00;
	endproperty
	a_start_clears_fresh: assert property (p_start_clears_fresh) else $error("stale data marked fresh"); // R7

	property p_set_count_rolls;
		@(posedge clock_i) disable iff (!rst_b_i)
		conv_i.done |=> s_reg.set_cnt == 3'($past(s_reg.set_cnt) + 3'h1);
	endproperty
	a_set_count_rolls: assert property (p_set_count_rolls) else $error("set count wrong"); // R8

	property p_cause_code;
		@(posedge clock_i) disable iff (!rst_b_i)
		host_i.rd && host_i.addr == hlr_pkg::OFF_CONV_STATE
		|=> rd_data_o[1:0] == $past({sys_flag_i, afe_flag_i}) && rd_data_o[15:14] == 2'b00;
	endproperty
	a_cause_code: assert property (p_cause_code) else $error("cause code wrong"); // R9

	property p_result_write_ignored;
		@(posedge clock_i) disable iff (!rst_b_i)
		host_i.wr && host_i.addr == hlr_pkg::OFF_X_VALUE && !conv_i.upd[0]
		|=> s_reg.res[0] == $past(s_reg.res[0]);
	endproperty
	a_result_write_ignored: assert property (p_result_write_ignored) else $error("result took a write"); // R15

	property p_single_violation_alerts;
		@(posedge clock_i) disable iff (!rst_b_i)
		conv_i.upd[0] && over[0] && limit_persistence_count_i == 2'h0 && $stable(limit_persistence_count_i)
		|=> ##1 limit_alert_o[0];
	endproperty
	a_single_violation_alerts: assert property (p_single_violation_alerts) else $error("alert late"); // R13

	property p_latch_holds;
		@(posedge clock_i) disable iff (!rst_b_i)
		alert_latch_i && limit_alert_o[0] && !(host_i.rd &&
			(host_i.addr == hlr_pkg::OFF_X_VALUE || host_i.addr == hlr_pkg::OFF_CONV_STATE))
		|=> limit_alert_o[0] || !alert_latch_i;
	endproperty
	a_latch_holds: assert property (p_latch_holds) else $error("latched alert dropped"); // R14

	property p_rd_valid_pulse;
		@(posedge clock_i) disable iff (!rst_b_i)
		host_i.rd
		|=> rd_valid_o;
	endproperty
	a_rd_valid_pulse: assert property (p_rd_valid_pulse) else $error("read answer missing"); // R12

	property p_no_rd_no_valid;
		@(posedge clock_i) disable iff (!rst_b_i)
		!host_i.rd
		|=> !rd_valid_o;
	endproperty
	a_no_rd_no_valid: assert property (p_no_rd_no_valid) else $error("spurious read answer"); // R12

	property p_rd_data_holds;
		@(posedge clock_i) disable iff (!rst_b_i)
		!host_i.rd
		|=> $stable(rd_data_o);
	endproperty
	a_rd_data_holds: assert property (p_rd_data_holds) else $error("read data changed"); // R10

	property p_status_reserved;
		@(posedge clock_i) disable iff (!rst_b_i)
		host_i.rd && host_i.addr == hlr_pkg::OFF_CONV_STATE
		|=> rd_data_o[15:14] == 2'b00 && rd_data_o[7] == 1'b0 && rd_data_o[3:2] == 2'b00;
	endproperty
	a_status_reserved: assert property (p_status_reserved) else $error("reserved status bit set"); // R15

	property p_status_valid_read;
		@(posedge clock_i) disable iff (!rst_b_i)
		host_i.rd && host_i.addr == hlr_pkg::OFF_CONV_STATE
		|=> rd_data_o[13] == $past(s_reg.valid);
	endproperty
	a_status_valid_read: assert property (p_status_valid_read) else $error("valid bit read wrong"); // R6

	property p_status_fresh_read;
		@(posedge clock_i) disable iff (!rst_b_i)
		host_i.rd && host_i.addr == hlr_pkg::OFF_CONV_STATE
		|=> rd_data_o[12:8] == $past(s_reg.fresh);
	endproperty
	a_status_fresh_read: assert property (p_status_fresh_read) else $error("fresh bits read wrong"); // R7

	property p_status_count_read;
		@(posedge clock_i) disable iff (!rst_b_i)
		host_i.rd && host_i.addr == hlr_pkg::OFF_CONV_STATE
		|=> rd_data_o[6:4] == $past(s_reg.set_cnt);
	endproperty
	a_status_count_read: assert property (p_status_count_read) else $error("set count read wrong"); // R8

	property p_axis_result_read;
		@(posedge clock_i) disable iff (!rst_b_i)
		host_i.rd && host_i.addr == hlr_pkg::OFF_X_VALUE
		|=> rd_data_o == $past(s_reg.res[0]);
	endproperty
	a_axis_result_read: assert property (p_axis_result_read) else $error("axis result read wrong"); // R10

	property p_thermal_result_read;
		@(posedge clock_i) disable iff (!rst_b_i)
		host_i.rd && host_i.addr == hlr_pkg::OFF_T_VALUE
		|=> rd_data_o == $past(s_reg.res[3]);
	endproperty
	a_thermal_result_read: assert property (p_thermal_result_read) else $error("thermal result wrong"); // R11

	property p_unmapped_read_zero;
		@(posedge clock_i) disable iff (!rst_b_i)
		host_i.rd && (host_i.addr < hlr_pkg::OFF_X_LIMITS || host_i.addr > hlr_pkg::OFF_T_VALUE)
		|=> rd_data_o == 16'h0000;
	endproperty
	a_unmapped_read_zero: assert property (p_unmapped_read_zero) else $error("unmapped read not zero"); // R15

	property p_upd_stores_result;
		@(posedge clock_i) disable iff (!rst_b_i)
		conv_i.upd[1]
		|=> s_reg.res[1] == $past(conv_i.data[1]);
	endproperty
	a_upd_stores_result: assert property (p_upd_stores_result) else $error("result not stored"); // R10

	property p_upd_marks_fresh;
		@(posedge clock_i) disable iff (!rst_b_i)
		conv_i.upd[2]
		|=> s_reg.fresh[2];
	endproperty
	a_upd_marks_fresh: assert property (p_upd_marks_fresh) else $error("channel not fresh"); // R7

	property p_angle_marks_fresh;
		@(posedge clock_i) disable iff (!rst_b_i)
		conv_i.angle_upd
		|=> s_reg.fresh[4];
	endproperty
	a_angle_marks_fresh: assert property (p_angle_marks_fresh) else $error("angle not fresh"); // R7

	property p_status_write_ignored;
		@(posedge clock_i) disable iff (!rst_b_i)
		host_i.wr && host_i.addr == hlr_pkg::OFF_CONV_STATE && !conv_i.start && !conv_i.done && !conv_i.angle_upd
		|=> $stable(s_reg.valid) && $stable(s_reg.set_cnt);
	endproperty
	a_status_write_ignored: assert property (p_status_write_ignored) else $error("status took a write"); // R15

	property p_thermal_limit_write;
		@(posedge clock_i) disable iff (!rst_b_i)
		host_i.wr && host_i.addr == hlr_pkg::OFF_T_LIMITS
		|=> s_reg.lim[3] == $past(host_i.wdata);
	endproperty
	a_thermal_limit_write: assert property (p_thermal_limit_write) else $error("thermal limit write lost"); // R4

	property p_count_holds;
		@(posedge clock_i) disable iff (!rst_b_i)
		!conv_i.done
		|=> $stable(s_reg.set_cnt);
	endproperty
	a_count_holds: assert property (p_count_holds) else $error("set count moved"); // R8

	property p_read_clears_latch;
		@(posedge clock_i) disable iff (!rst_b_i)
		alert_latch_i && host_i.rd && host_i.addr == hlr_pkg::OFF_X_VALUE && !hit[0]
		|=> !limit_alert_o[0];
	endproperty
	a_read_clears_latch: assert property (p_read_clears_latch) else $error("latched alert not cleared"); // R14

endmodule

// *** verilog/hlr_pkg.sv ***
package hlr_pkg;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [3:0] OFF_X_LIMITS  = 4'h4;
	localparam logic [3:0] OFF_Y_LIMITS  = 4'h5;
	localparam logic [3:0] OFF_Z_LIMITS  = 4'h6;
	localparam logic [3:0] OFF_T_LIMITS  = 4'h7;
	localparam logic [3:0] OFF_CONV_STATE = 4'h8;
	localparam logic [3:0] OFF_X_VALUE   = 4'h9;
	localparam logic [3:0] OFF_Y_VALUE   = 4'ha;
	localparam logic [3:0] OFF_Z_VALUE   = 4'hb;
	localparam logic [3:0] OFF_T_VALUE   = 4'hc;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int UPPER_MSB      = 15;
	localparam int UPPER_LSB      = 8;
	localparam int LOWER_MSB      = 7;
	localparam int LOWER_LSB      = 0;
	localparam int STAT_VALID_BIT = 13;
	localparam int STAT_FRESH_MSB = 12;
	localparam int STAT_FRESH_LSB = 8;
	localparam int STAT_SET_MSB   = 6;
	localparam int STAT_SET_LSB   = 4;
	localparam int STAT_CAUSE_MSB = 1;
	localparam int STAT_CAUSE_LSB = 0;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [15:0] RST_AXIS_LIMITS  = 16'h7d83;
	localparam logic [15:0] RST_THERM_LIMITS = 16'h6732;
	localparam logic [15:0] RST_VALUE        = 16'h0000;

	// Consecutive out-of-limit conversions saturate here (count field 3 = four)
	localparam logic [2:0] PERSIST_MAX = 3'h4;

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [3:0]  addr;
		logic [15:0] wdata;
	} hlr_host_req_t;

	// Channel order everywhere: 0 X, 1 Y, 2 Z, 3 temperature
	typedef struct packed {
		logic              start;
		logic              done;
		logic              angle_upd;
		logic [3:0]        upd;
		logic [3:0][15:0]  data;
	} hlr_conv_t;

	typedef struct packed {
		logic [3:0][15:0] lim;
		logic [3:0][15:0] res;
		logic             valid;
		logic [4:0]       fresh;
		logic [2:0]       set_cnt;
		logic [3:0][2:0]  persist;
		logic [3:0]       latch;
		logic [3:0]       alert;
		logic             rd_valid;
		logic [15:0]      rd_data;
	} hlr_state_t;

	localparam hlr_state_t STATE_RESET = '{
		lim:      {RST_THERM_LIMITS, RST_AXIS_LIMITS, RST_AXIS_LIMITS, RST_AXIS_LIMITS},
		res:      {RST_VALUE, RST_VALUE, RST_VALUE, RST_VALUE},
		valid:    1'b0,
		fresh:    5'h00,
		set_cnt:  3'h0,
		persist:  12'h000,
		latch:    4'h0,
		alert:    4'h0,
		rd_valid: 1'b0,
		rd_data:  16'h0000
	};

endpackage

// *** verification/hlr_host.sv ***
`timescale 1ns/100ps
module hlr_host
(
	input  wire logic              clock_i,
	input  wire logic              rd_valid_i,
	input  wire logic [15:0]       rd_data_i,
	output hlr_pkg::hlr_host_req_t host_o
);
	initial host_o = '0;
	// Released address and data are inverted, never left stale
	task automatic write(input logic [3:0] a, input logic [15:0] d);
		@(posedge clock_i);
		host_o <= {1'b1, 1'b0, a, d};
		@(posedge clock_i);
		host_o <= {1'b0, 1'b0, ~a, ~d};
	endtask
	task automatic read(input logic [3:0] a, output logic [15:0] d, output logic ok);
		@(posedge clock_i);
		host_o <= {1'b0, 1'b1, a, host_o.wdata};
		@(posedge clock_i);
		host_o <= {1'b0, 1'b0, ~a, ~host_o.wdata};
		ok = 1'b0;
		for (int n = 0; n < 3 && !ok; n++)
		begin
			@(negedge clock_i);
			ok = rd_valid_i;
			d = rd_data_i;
		end
	endtask
endmodule

// *** verification/testbench.sv ***
`timescale 1ns/100ps
module testbench;
	logic                 clock_i = 1'b0;
	logic                 rst_b_i = 1'b0;
	hlr_pkg::hlr_host_req_t host;
	hlr_pkg::hlr_conv_t   conv = '0;
	logic [1:0]           flags = 2'h0;
	logic                 latch = 1'b0;
	logic [1:0]           pc = 2'h0;
	logic [3:0]           en = 4'h0;
	logic                 rd_valid;
	logic [15:0]          rd_data;
	logic [3:0]           alert;
	logic [3:0][15:0]     dat = '0;
	logic [15:0]          lim[4] = '{16'h7d83, 16'h7d83, 16'h7d83, 16'h6732};
	logic [15:0]          res[4] = '{16'h0, 16'h0, 16'h0, 16'h0};
	logic                 valid = 1'b0;
	logic [4:0]           fresh = 5'h0;
	logic [2:0]           setc = 3'h0;
	int                   fails = 0;
	int                   samples_checked = 0;
	int                   seed = 32'hf2dc82c0;
	always #4 clock_i = ~clock_i;
	hlr_regs hlr_regs_inst (.clock_i(clock_i), .rst_b_i(rst_b_i), .host_i(host), .rd_valid_o(rd_valid),
		.rd_data_o(rd_data), .conv_i(conv), .afe_flag_i(flags[0]), .sys_flag_i(flags[1]),
		.alert_latch_i(latch), .limit_persistence_count_i(pc), .limit_check_en_i(en), .limit_alert_o(alert));
	hlr_host hlr_host_inst (.clock_i(clock_i), .rd_valid_i(rd_valid), .rd_data_i(rd_data), .host_o(host));
	// ----------------------------------------
	// Reference model and helpers
	// ----------------------------------------
	function automatic logic [15:0] expv(input logic [3:0] a);
		if (a >= 4'h4 && a <= 4'h7) return lim[a - 4'h4];
		if (a == 4'h8) return {2'b0, valid, fresh, 1'b0, setc, 2'b0, flags};
		if (a >= 4'h9 && a <= 4'hc) return res[a - 4'h9];
		return 16'h0000;
	endfunction
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e)
		begin
			fails++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic rchk(input logic [3:0] a);
		logic [15:0] d;
		logic        ok;
		host_inst_read: hlr_host_inst.read(a, d, ok);
		if (!ok)
		begin
			fails++;
			$display("ERROR rd_valid_o expected 1 seen 0");
			end_of_test();
		end
		else
			check($sformatf("register %h", a), expv(a), d);
	endtask
	task automatic conv_go(input logic st, input logic dn, input logic an, input logic [3:0] up);
		@(posedge clock_i);
		conv <= {st, dn, an, up, dat};
		@(posedge clock_i);
		conv <= {4'h0, 3'h0, dat};
		if (st) {valid, fresh} = 6'h00;
		for (int i = 0; i < 4; i++)
			if (up[i]) {res[i], fresh[i]} = {dat[i], 1'b1};
		if (an) fresh[4] = 1'b1;
		if (dn) {valid, setc} = {1'b1, setc + 3'h1};
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial
	begin
		logic [15:0] d;
		logic [4:0]  u;
		logic [3:0]  ea;
		repeat (5) @(posedge clock_i);
		rst_b_i <= 1'b1;
		for (int a = 0; a < 16; a++) rchk(4'(a));
		for (int a = 0; a < 16; a++)
		begin
			d = 16'($random(seed));
			hlr_host_inst.write(4'(a), d);
			if (a >= 4 && a <= 7) lim[a - 4] = d;
		end
		for (int a = 0; a < 16; a++) rchk(4'(a));
		$display("test registers done");
		for (int s = 0; s < 9; s++)
		begin
			u = 5'($random(seed));
			@(posedge clock_i);
			flags <= 2'(s);
			conv_go(1'b1, 1'b0, 1'b0, 4'h0);
			rchk(4'h8);
			for (int i = 0; i < 4; i++) dat[i] = 16'($random(seed));
			conv_go(1'b0, 1'b0, u[4], u[3:0]);
			conv_go(1'b0, 1'b1, 1'b0, 4'h0);
			for (int a = 8; a < 13; a++) rchk(4'(a));
		end
		$display("test conversions done");
		for (int a = 4; a < 8; a++) hlr_host_inst.write(4'(a), 16'h1000);
		lim = '{16'h1000, 16'h1000, 16'h1000, 16'h1000};
		dat = {4{16'h0800}};
		@(posedge clock_i);
		en <= 4'hf;
		conv_go(1'b0, 1'b0, 1'b0, 4'hf);
		for (int c = 0; c < 4; c++)
		begin
			@(posedge clock_i);
			pc <= 2'(c);
			for (int k = 1; k <= 5; k++)
			begin
				dat[c] = k[0] ? 16'h2000 : 16'hf000;
				conv_go(1'b0, 1'b0, 1'b0, 4'(1 << c));
				repeat (3) @(negedge clock_i);
				ea = (k > c) ? 4'(1 << c) : 4'h0;
				check("limit_alert_o", {12'h0, ea}, {12'h0, alert});
			end
			dat[c] = 16'h0800;
			conv_go(1'b0, 1'b0, 1'b0, 4'(1 << c));
		end
		@(posedge clock_i);
		{latch, pc} <= 3'h4;
		rchk(4'h8);
		dat[0] = 16'h2000;
		conv_go(1'b0, 1'b0, 1'b0, 4'h1);
		dat[0] = 16'h0800;
		conv_go(1'b0, 1'b0, 1'b0, 4'h1);
		repeat (3) @(negedge clock_i);
		check("limit_alert_o", 16'h0001, {12'h0, alert});
		rchk(4'h9);
		repeat (3) @(negedge clock_i);
		check("limit_alert_o", 16'h0000, {12'h0, alert});
		$display("test alerts done");
		end_of_test();
	end
endmodule
